// file: inc/rsc_pkg.sv
// Constants, types and register map for the rotate/subtract flag datapath.
package rsc_pkg;

  // Bus geometry.
  localparam int AXI_AW = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] OPND_OFS = 12'h004;
  localparam logic [11:0] FLAGS_OFS = 12'h008;
  localparam logic [11:0] STAT_OFS = 12'h00c;
  localparam logic [11:0] RF_BASE = 12'h100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Opcodes handled by this datapath.
  localparam logic [7:0] OPC_ROLC_DIR = 8'h10;
  localparam logic [7:0] OPC_ROLC_IND = 8'h11;
  localparam logic [7:0] OPC_ROR_DIR = 8'he0;
  localparam logic [7:0] OPC_RORC_DIR = 8'hc0;
  localparam logic [7:0] OPC_RORC_IND = 8'hc1;
  localparam logic [7:0] OPC_BANK0 = 8'h4f;
  localparam logic [7:0] OPC_BANK1 = 8'h5f;
  localparam logic [7:0] OPC_SUBB_WW = 8'h32;
  localparam logic [7:0] OPC_SUBB_WI = 8'h33;
  localparam logic [7:0] OPC_SUBB_GG = 8'h34;
  localparam logic [7:0] OPC_SUBB_GI = 8'h35;
  localparam logic [7:0] OPC_SUBB_IMM = 8'h36;
  localparam logic [7:0] OPC_SETC = 8'hdf;

  // Instruction lengths in CPU clock cycles.
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;

  // Flag register layout; bit 1 is reserved and reads as zero.
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  localparam int FLG_BANK = 0;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] FLAGS_MASK = 8'hfd;

  // Status register layout.
  localparam int STAT_BUSY = 0;
  localparam int STAT_BAD = 1;

  typedef enum logic [2:0] {
    CL_NONE, CL_ROLC, CL_ROR, CL_RORC, CL_BANK0, CL_BANK1, CL_SUBB, CL_SETC
  } rsc_class_e;

  // Operand byte layouts inside the operand register.
  typedef enum logic [2:0] {
    FMT_NONE, FMT_ONE, FMT_NIB, FMT_SD, FMT_DI
  } rsc_fmt_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_PTR = 3'b010,
    S_RUN = 3'b100
  } rsc_state_e;

  typedef struct packed {
    rsc_class_e cls;
    rsc_fmt_e fmt;
    logic dst_ind;
    logic src_ind;
    logic [2:0] cycles;
  } rsc_dec_s;

endpackage

// file: core/rsc_alu.sv
// Combinational result and flag logic for rotates, subtract and flag ops.
`timescale 1ns/1ps
module rsc_alu
  import rsc_pkg::*;
(
  input wire rsc_class_e cls,
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire logic [7:0] flags,
  output logic [7:0] res,
  output logic [7:0] next_flags,
  output logic wr_res
);

  logic [8:0] sum;
  logic [4:0] lo;
  logic rot;

  // Subtraction adds the inverted source and the inverted carry.
  always_comb begin
    res = dst;
    next_flags = flags;
    wr_res = 1'b0;
    sum = 9'h000;
    lo = 5'h00;
    rot = 1'b0;
    case (cls)
      CL_ROLC: begin
        res = {dst[6:0], flags[FLG_C]};
        next_flags[FLG_C] = dst[7];
        rot = 1'b1;
      end
      CL_ROR: begin
        res = {dst[0], dst[7:1]};
        next_flags[FLG_C] = dst[0];
        rot = 1'b1;
      end
      CL_RORC: begin
        res = {flags[FLG_C], dst[7:1]};
        next_flags[FLG_C] = dst[0];
        rot = 1'b1;
      end
      CL_BANK0: next_flags[FLG_BANK] = 1'b0;
      CL_BANK1: next_flags[FLG_BANK] = 1'b1;
      CL_SUBB: begin
        sum = {1'b0, dst} + {1'b0, ~src} + {8'h00, ~flags[FLG_C]};
        lo = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + {4'h0, ~flags[FLG_C]};
        res = sum[7:0];
        next_flags[FLG_C] = ~sum[8];
        next_flags[FLG_V] = (dst[7] != src[7]) && (res[7] == src[7]);
        next_flags[FLG_D] = 1'b1;
        next_flags[FLG_H] = ~lo[4];
        next_flags[FLG_Z] = (res == 8'h00);
        next_flags[FLG_S] = res[7];
        wr_res = 1'b1;
      end
      CL_SETC: next_flags[FLG_C] = 1'b1;
      default: wr_res = 1'b0;
    endcase
    // Rotates share sign, zero and overflow; D and H stay as they were.
    if (rot) begin
      next_flags[FLG_V] = res[7] ^ dst[7];
      next_flags[FLG_Z] = (res == 8'h00);
      next_flags[FLG_S] = res[7];
      wr_res = 1'b1;
    end
  end

endmodule

// file: core/rsc_core.sv
// Rotate, subtract-with-borrow and flag datapath with an AXI4-Lite port.
//
// How it works
// - Rotate left through carry, carry feeds bit 0.
// - Left rotate opcodes 10/11, four cycles.
// - Rotate right copies bit 0 to 7, carry.
// - Rotate right through carry, opcodes C0/C1.
// - Rotates set overflow when bit 7 changes.
// - Rotates set zero, sign; keep D and H.
// - Bank zero op clears flag bit 0.
// - Bank one op sets flag bit 0.
// - Subtract writes dst minus src minus carry.
// - Subtract adds complement; opcodes 32 to 36.
// - Subtract sets carry on borrow.
// - Subtract overflow from operand and result signs.
// - Subtract sets D; H marks nibble borrow.
// - Subtract sets zero and sign from result.
// - Set carry op forces carry, four cycles.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rsc_core
  import rsc_pkg::*;
#(
  parameter int REG_AW = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int DEPTH = 1 << REG_AW;

  logic [7:0] regs [DEPTH];
  logic [7:0] flags;
  logic [15:0] opnd;
  logic [7:0] res_q;
  logic bad_op;
  rsc_state_e state;
  logic [2:0] cnt;
  rsc_dec_s dec_q;
  rsc_dec_s dec_now;
  logic [7:0] dst_a;
  logic [7:0] src_a;
  logic [7:0] imm_q;
  logic [7:0] op_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_wr;
  logic wr_ctrl;
  logic wr_opnd;
  logic wr_flags;
  logic wr_rf;
  logic wr_hit;
  logic idle;
  logic start;
  logic commit;
  logic [7:0] dst_v;
  logic [7:0] src_v;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic alu_wr;

  // True when the address falls in the byte-wide register file window.
  function automatic logic rf_hit(input logic [AXI_AW-1:0] a);
    rf_hit = (a[AXI_AW-1:8] == RF_BASE[AXI_AW-1:8]) &&
             (int'(a[7:2]) < DEPTH);
  endfunction

  // True when the address selects the given word register.
  function automatic logic reg_hit(input logic [AXI_AW-1:0] a,
                                   input logic [AXI_AW-1:0] ofs);
    reg_hit = (a[AXI_AW-1:2] == ofs[AXI_AW-1:2]);
  endfunction

  // Maps an opcode to its class, operand layout and length.
  function automatic rsc_dec_s decode(input logic [7:0] op);
    rsc_dec_s d;
    d = '{cls: CL_NONE, fmt: FMT_NONE, dst_ind: 1'b0, src_ind: 1'b0,
          cycles: CYC_SHORT};
    case (op)
      OPC_ROLC_DIR: begin
        d.cls = CL_ROLC;
        d.fmt = FMT_ONE;
      end
      OPC_ROLC_IND: begin
        d.cls = CL_ROLC;
        d.fmt = FMT_ONE;
        d.dst_ind = 1'b1;
      end
      OPC_ROR_DIR: begin
        d.cls = CL_ROR;
        d.fmt = FMT_ONE;
      end
      OPC_RORC_DIR: begin
        d.cls = CL_RORC;
        d.fmt = FMT_ONE;
      end
      OPC_RORC_IND: begin
        d.cls = CL_RORC;
        d.fmt = FMT_ONE;
        d.dst_ind = 1'b1;
      end
      OPC_BANK0: d.cls = CL_BANK0;
      OPC_BANK1: d.cls = CL_BANK1;
      OPC_SETC: d.cls = CL_SETC;
      OPC_SUBB_WW: begin
        d.cls = CL_SUBB;
        d.fmt = FMT_NIB;
      end
      OPC_SUBB_WI: begin
        d.cls = CL_SUBB;
        d.fmt = FMT_NIB;
        d.src_ind = 1'b1;
        d.cycles = CYC_LONG;
      end
      OPC_SUBB_GG: begin
        d.cls = CL_SUBB;
        d.fmt = FMT_SD;
        d.cycles = CYC_LONG;
      end
      OPC_SUBB_GI: begin
        d.cls = CL_SUBB;
        d.fmt = FMT_SD;
        d.src_ind = 1'b1;
        d.cycles = CYC_LONG;
      end
      OPC_SUBB_IMM: begin
        d.cls = CL_SUBB;
        d.fmt = FMT_DI;
        d.cycles = CYC_LONG;
      end
      default: d.cls = CL_NONE;
    endcase
    return d;
  endfunction

  // Write path: address and data are taken independently, then applied.
  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign idle = (state == S_IDLE);
  assign dec_now = decode(w_data_q[7:0]);

  // Register selects for the write being applied this cycle.
  always_comb begin
    wr_ctrl = do_wr && reg_hit(aw_addr_q, CTRL_OFS);
    wr_opnd = do_wr && reg_hit(aw_addr_q, OPND_OFS);
    wr_flags = do_wr && reg_hit(aw_addr_q, FLAGS_OFS);
    wr_rf = do_wr && rf_hit(aw_addr_q);
    wr_hit = wr_ctrl || wr_opnd || wr_flags || wr_rf ||
             reg_hit(aw_addr_q, STAT_OFS);
    start = wr_ctrl && w_strb_q[0] && idle && (dec_now.cls != CL_NONE);
  end

  // Write channel handshakes and the write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Operand register; only loaded while no instruction is running.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opnd <= 16'h0000;
    end else if (wr_opnd && idle) begin
      if (w_strb_q[0]) begin
        opnd[7:0] <= w_data_q[7:0];
      end
      if (w_strb_q[1]) begin
        opnd[15:8] <= w_data_q[15:8];
      end
    end
  end

  // Sequencer: operand fetch, then run until the last cycle commits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      cnt <= 3'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            state <= S_PTR;
            cnt <= dec_now.cycles - 3'h1;
          end
        end
        S_PTR: begin
          state <= S_RUN;
          cnt <= cnt - 3'h1;
        end
        S_RUN: begin
          if (cnt == 3'h0) begin
            state <= S_IDLE;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign commit = (state == S_RUN) && (cnt == 3'h0);

  // Operand addresses; indirect forms replace them with the pointed value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_q <= '0;
      op_q <= 8'h00;
      dst_a <= 8'h00;
      src_a <= 8'h00;
      imm_q <= 8'h00;
    end else if (start) begin
      dec_q <= dec_now;
      op_q <= w_data_q[7:0];
      imm_q <= opnd[15:8];
      case (dec_now.fmt)
        FMT_NIB: begin
          dst_a <= {4'h0, opnd[7:4]};
          src_a <= {4'h0, opnd[3:0]};
        end
        FMT_SD: begin
          dst_a <= opnd[15:8];
          src_a <= opnd[7:0];
        end
        default: begin
          dst_a <= opnd[7:0];
          src_a <= opnd[7:0];
        end
      endcase
    end else if (state == S_PTR) begin
      if (dec_q.dst_ind) begin
        dst_a <= dst_v;
      end
      if (dec_q.src_ind) begin
        src_a <= regs[src_a[REG_AW-1:0]];
      end
    end
  end

  assign dst_v = regs[dst_a[REG_AW-1:0]];
  assign src_v = (dec_q.fmt == FMT_DI) ? imm_q : regs[src_a[REG_AW-1:0]];

  rsc_alu u_alu (
    .cls(dec_q.cls),
    .dst(dst_v),
    .src(src_v),
    .flags(flags),
    .res(alu_res),
    .next_flags(alu_flags),
    .wr_res(alu_wr)
  );

  // Register file: the commit writes the result, software loads when idle.
  always_ff @(posedge aclk) begin
    if (commit && alu_wr) begin
      regs[dst_a[REG_AW-1:0]] <= alu_res;
    end else if (wr_rf && idle && w_strb_q[0]) begin
      regs[aw_addr_q[REG_AW+1:2]] <= w_data_q[7:0];
    end
  end

  // Flags change only at commit, or by a software write when idle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= FLAGS_RST;
    end else if (commit) begin
      flags <= alu_flags & FLAGS_MASK;
    end else if (wr_flags && idle && w_strb_q[0]) begin
      flags <= w_data_q[7:0] & FLAGS_MASK;
    end
  end

  // Last result and the unknown-opcode status bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_q <= 8'h00;
      bad_op <= 1'b0;
    end else begin
      if (commit && alu_wr) begin
        res_q <= alu_res;
      end
      if (wr_ctrl && w_strb_q[0] && idle) begin
        bad_op <= (dec_now.cls == CL_NONE);
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (reg_hit(s_axi_araddr, CTRL_OFS)) begin
        s_axi_rdata[7:0] <= op_q;
      end else if (reg_hit(s_axi_araddr, OPND_OFS)) begin
        s_axi_rdata[15:0] <= opnd;
      end else if (reg_hit(s_axi_araddr, FLAGS_OFS)) begin
        s_axi_rdata[7:0] <= flags;
      end else if (reg_hit(s_axi_araddr, STAT_OFS)) begin
        s_axi_rdata[STAT_BUSY] <= !idle;
        s_axi_rdata[STAT_BAD] <= bad_op;
        s_axi_rdata[15:8] <= res_q;
      end else if (rf_hit(s_axi_araddr)) begin
        s_axi_rdata[7:0] <= regs[s_axi_araddr[REG_AW+1:2]];
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks tying committed values to the operands seen at commit, plus short instruction length and pointer fetch.
  a_rolc_result: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && dec_q.cls == CL_ROLC |=> dst_v ==
      {$past(dst_v[6:0]), $past(flags[FLG_C])} &&
      flags[FLG_C] == $past(dst_v[7]))
    else $error("rotate left through carry result wrong");

  a_short_length: assert property (@(posedge aclk) disable iff (!aresetn)
    start && dec_now.cycles == CYC_SHORT |=>
      (state != S_IDLE)[*4] ##1 state == S_IDLE)
    else $error("short instruction length wrong");

  a_ror_result: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && dec_q.cls == CL_ROR |=>
      res_q == {$past(dst_v[0]), $past(dst_v[7:1])} &&
      flags[FLG_C] == $past(dst_v[0]))
    else $error("rotate right result wrong");

  a_rorc_result: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && dec_q.cls == CL_RORC |=>
      res_q == {$past(flags[FLG_C]), $past(dst_v[7:1])} &&
      flags[FLG_C] == $past(dst_v[0]))
    else $error("rotate right through carry result wrong");

  a_rot_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && alu_wr && dec_q.cls != CL_SUBB |=>
      flags[FLG_V] == (res_q[7] ^ $past(dst_v[7])) &&
      flags[FLG_Z] == (res_q == 8'h00) && flags[FLG_S] == res_q[7] &&
      flags[FLG_D] == $past(flags[FLG_D]) &&
      flags[FLG_H] == $past(flags[FLG_H]))
    else $error("rotate flags wrong");

  a_bank_select: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && (dec_q.cls == CL_BANK0 || dec_q.cls == CL_BANK1) |=>
      flags[FLG_BANK] == ($past(dec_q.cls) == CL_BANK1) &&
      flags[7:1] == $past(flags[7:1]))
    else $error("bank select wrong");

  a_subb_result: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && dec_q.cls == CL_SUBB |=>
      {flags[FLG_C], res_q} == {1'b0, $past(dst_v)} - {1'b0, $past(src_v)}
        - {8'h00, $past(flags[FLG_C])})
    else $error("subtract with borrow result wrong");

  a_subb_dh: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && dec_q.cls == CL_SUBB |=> flags[FLG_D] &&
      flags[FLG_H] == ($past(dst_v[3:0]) <
        {1'b0, $past(src_v[3:0])} + {4'h0, $past(flags[FLG_C])}))
    else $error("subtract D or H flag wrong");

  a_scf_only: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && dec_q.cls == CL_SETC |=> flags[FLG_C] &&
      flags[6:0] == $past(flags[6:0]))
    else $error("set carry changed other flags");

  a_ptr_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
    state == S_PTR && dec_q.dst_ind |=> dst_a == $past(dst_v))
    else $error("indirect address not fetched");

endmodule

// file: verification/tb_rotate_subtract_carry_alu.sv
// Self-checking testbench for the rotate, subtract and flag datapath.
`timescale 1ns/1ps
module tb_rotate_subtract_carry_alu
  import rsc_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [AXI_AW-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [31:0] s_axi_rdata, rd_d;
  int bad_count = 0;
  int checks_done = 0;

  // Free-running 50 MHz clock.
  always #10 aclk = ~aclk;

  // Device under test with its default register file size.
  rsc_core i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  // Counts a comparison and reports it when the values differ.
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One AXI4-Lite write; address and data are offered together.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    if (n == 50) bad_count++;
    wr_r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  // One AXI4-Lite read; data and response are taken at the rvalid edge.
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    if (n == 50) bad_count++;
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Byte address of a register file entry.
  function automatic logic [11:0] rf(input int i);
    return RF_BASE + 12'(4 * i);
  endfunction

  // Reads a byte register and compares its low byte.
  task automatic rchk(input logic [11:0] a, input string nm,
                      input logic [7:0] e);
    rd(a);
    check(nm, {24'h0, rd_d[7:0]}, {24'h0, e});
  endtask

  // Polls the status register until the instruction has finished.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(STAT_OFS);
      n++;
    end while (rd_d[STAT_BUSY] !== 1'h0 && n < 20);
    if (n == 20) bad_count++;
  endtask

  // Loads operand and flags, then writes the opcode to start it.
  task automatic start(input logic [7:0] op, input logic [15:0] od,
                       input logic [7:0] fl);
    wr(OPND_OFS, {16'h0, od});
    wr(FLAGS_OFS, {24'h0, fl});
    wr(CTRL_OFS, {24'h0, op});
  endtask

  // Runs one instruction and checks the written byte and the flags.
  task automatic do_op(input logic [7:0] op, input logic [15:0] od,
                       input logic [7:0] fl, input int ri,
                       input logic [7:0] re, input logic [7:0] fe);
    start(op, od, fl);
    rd(STAT_OFS);
    check("busy", {31'h0, rd_d[STAT_BUSY]}, 32'h1);
    wait_idle();
    rchk(rf(ri), $sformatf("op %h result", op), re);
    rchk(FLAGS_OFS, $sformatf("op %h flags", op), fe);
  endtask

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected length of the run.
  initial begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    close_out();
  end

  // Main sequence of tests.
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    // Reset values, the reserved flag bit and an unmapped address.
    rchk(FLAGS_OFS, "flags reset", 8'h00);
    rchk(OPND_OFS, "operand reset", 8'h00);
    rchk(CTRL_OFS, "opcode reset", 8'h00);
    rd(STAT_OFS);
    check("status reset", rd_d, 32'h0);
    rd(12'h010);
    check("unmapped rresp", {30'h0, rd_r}, {30'h0, RESP_SLVERR});
    check("unmapped rdata", rd_d, 32'h0);
    wr(12'h010, 32'h5a);
    check("unmapped bresp", {30'h0, wr_r}, {30'h0, RESP_SLVERR});
    wr(FLAGS_OFS, 32'hff);
    rchk(FLAGS_OFS, "flags mask", 8'hfd);
    // Rotates: carry paths, overflow on sign change, D and H kept.
    wr(rf(0), 32'haa);
    do_op(8'h10, 16'h0000, 8'h0c, 0, 8'h54, 8'h9c);
    wr(rf(1), 32'h02);
    wr(rf(2), 32'h17);
    do_op(8'h11, 16'h0001, 8'h01, 2, 8'h2e, 8'h01);
    rchk(rf(1), "pointer kept", 8'h02);
    wr(rf(0), 32'h31);
    do_op(8'he0, 16'h0000, 8'h00, 0, 8'h98, 8'hb0);
    wr(rf(0), 32'h55);
    do_op(8'hc0, 16'h0000, 8'h00, 0, 8'h2a, 8'h80);
    do_op(8'hc1, 16'h0001, 8'h8c, 2, 8'h97, 8'h3c);
    wr(rf(3), 32'h80);
    do_op(8'h10, 16'h0003, 8'h00, 3, 8'h00, 8'hd0);
    // Bank and carry flag operations leave the data byte alone.
    do_op(8'h5f, 16'h0000, 8'hfc, 0, 8'h2a, 8'hfd);
    do_op(8'h4f, 16'h0000, 8'hfd, 0, 8'h2a, 8'hfc);
    do_op(8'hdf, 16'h0000, 8'h7d, 0, 8'h2a, 8'hfd);
    do_op(8'hdf, 16'h0000, 8'h80, 0, 8'h2a, 8'h80);
    // Subtract with borrow in every addressing form.
    wr(rf(1), 32'h10);
    wr(rf(2), 32'h03);
    do_op(8'h32, 16'h0012, 8'h81, 1, 8'h0c, 8'h0d);
    rchk(rf(2), "source kept", 8'h03);
    wr(rf(1), 32'h10);
    wr(rf(3), 32'h0a);
    do_op(8'h33, 16'h0012, 8'h81, 1, 8'h05, 8'h0d);
    wr(rf(1), 32'h20);
    do_op(8'h34, 16'h0102, 8'h81, 1, 8'h1c, 8'h0d);
    wr(rf(1), 32'h20);
    do_op(8'h35, 16'h0102, 8'h81, 1, 8'h15, 8'h0d);
    wr(rf(4), 32'h05);
    do_op(8'h36, 16'h0404, 8'h80, 4, 8'h00, 8'h48);
    wr(rf(5), 32'h80);
    do_op(8'h36, 16'h0105, 8'h00, 5, 8'h7f, 8'h1c);
    wr(rf(6), 32'h03);
    do_op(8'h36, 16'h0306, 8'h80, 6, 8'hff, 8'hac);
    // Busy window: flag writes refused, result and flags land together.
    wr(rf(1), 32'h20);
    // The flag write lands in the fourth cycle of the six-cycle busy window.
    start(8'h36, 16'h8a01, 8'h81);
    wr(FLAGS_OFS, 32'h00);
    check("busy bresp", {30'h0, wr_r}, {30'h0, RESP_OKAY});
    wait_idle();
    check("status result", {24'h0, rd_d[15:8]}, 32'h95);
    rchk(rf(1), "borrow result", 8'h95);
    rchk(FLAGS_OFS, "borrow flags", 8'hbd);
    // Unknown opcode runs nothing and is flagged.
    wr(CTRL_OFS, 32'h90);
    rd(STAT_OFS);
    check("unknown opcode", {30'h0, rd_d[1:0]}, 32'h2);
    rchk(CTRL_OFS, "last opcode", 8'h36);
    rchk(FLAGS_OFS, "flags untouched", 8'hbd);
    close_out();
  end
endmodule
